/* File: dac_device.sv */
// converter control end: shift register, input register and output register
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module dac_device #(
  parameter int unsigned RESOLUTION = 12
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  supply_low_i,
  dac_link_if.device                 link,
  output logic                       reference_isolation_amp_on_o,
  output logic                       output_scale_select_n_o,
  output logic                       output_active_o,
  output logic [RESOLUTION-1:0]      dac_code_o,
  output logic                       input_loaded_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // link pins and the supply monitor come from outside this clock;
  // two flops each keep a metastable sample away from the logic
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] sdi_sync;
  logic [1:0] strobe_sync;
  logic [1:0] supply_sync;
  logic       cs_q;
  logic       sck_q;
  logic       hold_rst;

  // select resets to its idle high level, so no false edge follows reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cs_sync <= 2'h3;
      cs_q    <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], link.cs_n};
      cs_q    <= cs_sync[1];
    end
  end

  // resets low; a false rise after reset with a high idle clock
  // arrives while select is high and is dropped
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sck_sync <= 2'h0;
      sck_q    <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[0], link.sck};
      sck_q    <= sck_sync[1];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sdi_sync <= 2'h0;
    end else begin
      sdi_sync <= {sdi_sync[0], link.sdi};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      strobe_sync <= 2'h3;
    end else begin
      strobe_sync <= {strobe_sync[0], link.output_latch_strobe_n};
    end
  end

  // a supply dip shorter than one clock may be missed
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      supply_sync <= 2'h0;
    end else begin
      supply_sync <= {supply_sync[0], supply_low_i};
    end
  end

  // a low supply acts as a held reset of everything behind the pins
  assign hold_rst = srst_i || supply_sync[1];

  logic sck_rise;
  logic cs_rise;
  logic cs_low;
  assign cs_low   = ~cs_sync[1];
  // a rising edge seen while select is high is dropped
  assign sck_rise = sck_sync[1] & ~sck_q & cs_low;
  assign cs_rise  = cs_sync[1] & ~cs_q;

  // ----------------------------------------------------------------
  // shift path
  // ----------------------------------------------------------------
  logic [dac_link_pkg::WORD_BITS-1:0] shift;
  logic [dac_link_pkg::CNT_BITS-1:0]  bit_cnt;
  logic                               full;
  assign full = (bit_cnt == 5'(dac_link_pkg::WORD_BITS));

  always_ff @(posedge sys_clk_i) begin
    if (hold_rst) begin
      shift   <= '0;
      bit_cnt <= '0;
    end else if (!cs_low) begin
      bit_cnt <= '0;
    end else if (sck_rise && !full) begin
      shift   <= {shift[dac_link_pkg::WORD_BITS-2:0], sdi_sync[1]};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // input and output registers
  // ----------------------------------------------------------------
  logic                                in_ref_buf;
  logic                                in_gain_n;
  logic                                in_active;
  logic [dac_link_pkg::CODE_BITS-1:0]  in_code;
  logic                                in_valid;
  logic                                take;
  logic                                short_frame;
  logic                                ignored;
  logic                                copy;
  // fewer than sixteen clocks in the low period: the frame is aborted
  assign short_frame = !full;
  // bit 15 set asks for the whole command to be dropped
  assign ignored     = shift[dac_link_pkg::IGNORE_BIT];
  // only a complete, accepted frame loads at the select rise
  assign take        = cs_rise && !short_frame && !ignored;

  // configuration half of the input register
  always_ff @(posedge sys_clk_i) begin
    if (hold_rst) begin
      in_ref_buf <= dac_link_pkg::REF_BUF_RESET;
      in_gain_n  <= dac_link_pkg::GAIN_N_RESET;
      in_active  <= dac_link_pkg::ACTIVE_RESET;
    end else if (take) begin
      in_ref_buf <= shift[dac_link_pkg::REF_BUF_BIT];
      in_gain_n  <= shift[dac_link_pkg::GAIN_BIT];
      in_active  <= shift[dac_link_pkg::ACTIVE_BIT];
    end
  end

  // data half of the input register; state stays reset until a write
  always_ff @(posedge sys_clk_i) begin
    if (hold_rst) begin
      in_code  <= '0;
      in_valid <= 1'b0;
    end else if (take) begin
      in_code  <= shift[dac_link_pkg::CODE_MSB:0];
      in_valid <= 1'b1;
    end
  end

  // strobe is level sensitive: while it stays low every new load passes
  // straight on, which is how a tied-low strobe behaves
  assign copy = !strobe_sync[1] && in_valid;

  always_ff @(posedge sys_clk_i) begin
    if (hold_rst) begin
      reference_isolation_amp_on_o <= dac_link_pkg::REF_BUF_RESET;
      output_scale_select_n_o      <= dac_link_pkg::GAIN_N_RESET;
      output_active_o              <= dac_link_pkg::ACTIVE_RESET;
    end else if (copy) begin
      reference_isolation_amp_on_o <= in_ref_buf;
      output_scale_select_n_o      <= in_gain_n;
      output_active_o              <= in_active;
    end
  end

  // left aligned: narrow variants drop the low bits
  always_ff @(posedge sys_clk_i) begin
    if (hold_rst) begin
      dac_code_o <= '0;
    end else if (copy) begin
      dac_code_o <= in_code[dac_link_pkg::CODE_BITS-1 -: RESOLUTION];
    end
  end

  // one-cycle load pulse; no data output path exists on the link
  always_ff @(posedge sys_clk_i) begin
    if (hold_rst) begin
      input_loaded_o <= 1'b0;
    end else begin
      input_loaded_o <= take;
    end
  end
endmodule

/* File: dac_link_pkg.sv */
// shared constants for the serial converter link and its controller
package dac_link_pkg;
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned CODE_BITS    = 12;
  localparam int unsigned CNT_BITS     = 5;
  localparam int unsigned IGNORE_BIT   = 15;
  localparam int unsigned REF_BUF_BIT  = 14;
  localparam int unsigned GAIN_BIT     = 13;
  localparam int unsigned ACTIVE_BIT   = 12;
  localparam int unsigned CODE_MSB     = 11;
  // host register byte offsets
  localparam logic [7:0]  CMD_OFFSET    = 8'h00;
  localparam logic [7:0]  CTRL_OFFSET   = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET = 8'h08;
  localparam logic [7:0]  SCK_DIV_OFFSET = 8'h0c;
  localparam int unsigned DIV_BITS      = 8;
  localparam logic [7:0]  SCK_DIV_RESET = 8'h04;
  // device configuration after power-on
  localparam logic        REF_BUF_RESET = 1'b0;
  localparam logic        GAIN_N_RESET  = 1'b0;
  localparam logic        ACTIVE_RESET  = 1'b0;
endpackage

/* File: dac_link_if.sv */
// link between the host controller and the converter control logic
`timescale 1ns/1ps
interface dac_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic output_latch_strobe_n;
  modport host (output cs_n, output sck, output sdi, output output_latch_strobe_n);
  modport device (input cs_n, input sck, input sdi, input output_latch_strobe_n);
endinterface

/* File: dac_host.sv */
// host end: APB register slave driving the serial write link
`timescale 1ns/1ps
module dac_host (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  dac_link_if.host         link
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [dac_link_pkg::WORD_BITS-1:0] cmd;
  logic                               strobe_n;
  logic [dac_link_pkg::DIV_BITS-1:0]  div;
  logic                               busy;
  logic                               start;
  logic                               acc;
  logic                               mapped;

  assign acc    = psel && penable;
  assign mapped = (paddr == dac_link_pkg::CMD_OFFSET) || (paddr == dac_link_pkg::CTRL_OFFSET)
               || (paddr == dac_link_pkg::STATUS_OFFSET) || (paddr == dac_link_pkg::SCK_DIV_OFFSET);
  assign start  = acc && pwrite && (paddr == dac_link_pkg::CMD_OFFSET) && !busy;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cmd      <= '0;
      strobe_n <= 1'b1;
      div      <= dac_link_pkg::SCK_DIV_RESET;
    end else if (acc && pwrite) begin
      if (start) begin
        cmd <= pwdata[dac_link_pkg::WORD_BITS-1:0];
      end
      if (paddr == dac_link_pkg::CTRL_OFFSET) begin
        strobe_n <= ~pwdata[0];
      end
      if (paddr == dac_link_pkg::SCK_DIV_OFFSET && pwdata[7:0] != 8'h00) begin
        div <= pwdata[7:0];
      end
    end
  end

  // one-cycle answer: pready rises in the access phase
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          dac_link_pkg::CMD_OFFSET:     prdata <= {16'h0000, cmd};
          dac_link_pkg::CTRL_OFFSET:    prdata <= {31'h0, ~strobe_n};
          dac_link_pkg::STATUS_OFFSET:  prdata <= {31'h0, busy};
          dac_link_pkg::SCK_DIV_OFFSET: prdata <= {24'h0, div};
          default:                      prdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // serial engine: mode 0,0, msb first, select held over 16 bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, LOW, HIGH, DONE} phase_t;
  phase_t                             phase;
  logic [dac_link_pkg::DIV_BITS-1:0]  tick;
  logic [dac_link_pkg::WORD_BITS-1:0] sh;
  logic [dac_link_pkg::CNT_BITS-1:0]  sent;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      phase <= IDLE;
      tick  <= '0;
      sh    <= '0;
      sent  <= '0;
      busy  <= 1'b0;
    end else begin
      unique case (phase)
        IDLE: if (start) begin
          sh    <= pwdata[dac_link_pkg::WORD_BITS-1:0];
          sent  <= '0;
          tick  <= '0;
          busy  <= 1'b1;
          phase <= LOW;
        end
        LOW: if (tick == div) begin
          tick  <= '0;
          phase <= HIGH;
        end else begin
          tick <= tick + 8'h01;
        end
        HIGH: if (tick == div) begin
          tick <= '0;
          sh   <= {sh[dac_link_pkg::WORD_BITS-2:0], 1'b0};
          sent <= sent + 5'h01;
          phase <= (sent == 5'(dac_link_pkg::WORD_BITS - 1)) ? DONE : LOW;
        end else begin
          tick <= tick + 8'h01;
        end
        DONE: if (tick == div) begin
          busy  <= 1'b0;
          phase <= IDLE;
        end else begin
          tick <= tick + 8'h01;
        end
      endcase
    end
  end

  // link pins come straight from flops
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      link.cs_n                  <= 1'b1;
      link.sck                   <= 1'b0;
      link.sdi                   <= 1'b0;
      link.output_latch_strobe_n <= 1'b1;
    end else begin
      link.cs_n                  <= !(phase == LOW || phase == HIGH);
      link.sck                   <= (phase == HIGH);
      link.sdi                   <= sh[dac_link_pkg::WORD_BITS-1];
      link.output_latch_strobe_n <= strobe_n;
    end
  end
endmodule

/* File: dac_link_asserts.sv */
// checker for the serial write frames on the joined link
`timescale 1ns/1ps
module dac_link_asserts (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic output_latch_strobe_n
);
  logic [5:0] rises;
  // counts clock rises inside one select-low period
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || cs_n) rises <= 6'h00;
    else if ($rose(sck)) rises <= rises + 6'h01;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence open_s; $fell(cs_n); endsequence
  sequence close_s; ##[32:700] $rose(cs_n); endsequence
  a_idle_sck_low: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("clock moved while deselected");
  a_start_sck_low: assert property (open_s |-> !sck)
    else $error("frame opened with clock high");
  a_frame_bounded: assert property (open_s |-> close_s)
    else $error("frame length out of range");
  a_sixteen_clocks: assert property ($rose(cs_n) |-> rises == 6'h10)
    else $error("frame closed without sixteen clocks");
  a_no_extra_clk: assert property (!cs_n |-> rises <= 6'h10)
    else $error("more than sixteen clocks");
  a_data_setup: assert property ($rose(sck) |-> $stable(sdi))
    else $error("data moved at clock rise");
  a_half_period: assert property ($changed(sck) |=> $stable(sck) [*2])
    else $error("clock half period too short");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select high gap too short");
endmodule

/* File: tb.sv */
// self-checking bench: host and device joined, plus a bench-driven device
`timescale 1ns/1ps
module tb;
  logic        sys_clk_i  = 1'b0;
  logic        srst_i     = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        supply_low = 1'b0;
  logic        ref_a, gain_a, act_a, ref_b, gain_b, act_b;
  logic [11:0] code_a;
  logic [7:0]  code_b;
  logic        loaded_a, loaded_b;
  logic [15:0] words [4] = '{16'h0fff, 16'h1000, 16'h2001, 16'h5a5a};
  int          fail_count = 0;
  int          checks_done = 0;
  int          loads_a = 0;
  int          loads_b = 0;
  dac_link_if link_a ();
  dac_link_if link_b ();
  always #20 sys_clk_i = ~sys_clk_i;
  // count input register loads on both devices
  always @(posedge sys_clk_i) begin
    if (loaded_a === 1'b1) loads_a <= loads_a + 1;
    if (loaded_b === 1'b1) loads_b <= loads_b + 1;
  end
  initial begin
    link_b.cs_n = 1'b1;
    link_b.sck = 1'b0;
    link_b.sdi = 1'b0;
    link_b.output_latch_strobe_n = 1'b0;
  end
  dac_host u_dac_host (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_a));
  dac_device u_dac_device (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .supply_low_i(supply_low),
    .link(link_a), .reference_isolation_amp_on_o(ref_a), .output_scale_select_n_o(gain_a),
    .output_active_o(act_a), .dac_code_o(code_a), .input_loaded_o(loaded_a));
  // narrow variant driven by the bench, so faulty frames can be sent
  dac_device #(.RESOLUTION(8)) u_dac_device_b (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .supply_low_i(1'b0), .link(link_b), .reference_isolation_amp_on_o(ref_b),
    .output_scale_select_n_o(gain_b), .output_active_o(act_b), .dac_code_o(code_b),
    .input_loaded_o(loaded_b));
  dac_link_asserts u_dac_link_asserts (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .cs_n(link_a.cs_n), .sck(link_a.sck), .sdi(link_a.sdi),
    .output_latch_strobe_n(link_a.output_latch_strobe_n));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      complete_run();
    end
    @(posedge sys_clk_i);
  endtask
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    apb(1'b1, dac_link_pkg::CMD_OFFSET, {16'h0000, w});
    do begin
      apb(1'b0, dac_link_pkg::STATUS_OFFSET, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (rd[0] !== 1'b0) begin
      fail_count++;
      complete_run();
    end
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic expect_a(input logic [15:0] w);
    check({17'h0, ref_a, gain_a, act_a, code_a}, {17'h0, w[14:0]});
  endtask
  // the narrow variant keeps only the top eight code bits
  task automatic expect_b(input logic [15:0] w);
    check({21'h0, ref_b, gain_b, act_b, code_b}, {21'h0, w[14:4]});
  endtask
  // bit-banged frame; half period of four cycles gives a 320 ns link clock
  task automatic frame(input logic [15:0] w, input int n, input logic cs);
    link_b.cs_n <= cs;
    for (int i = 0; i < n; i++) begin
      link_b.sdi <= (i < 16) ? w[15-i] : 1'b1;
      repeat (4) @(posedge sys_clk_i);
      link_b.sck <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      link_b.sck <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    link_b.cs_n <= 1'b1;
    link_b.sdi <= ~link_b.sdi;
    repeat (12) @(posedge sys_clk_i);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    check({28'h0, link_a.cs_n, link_a.sck, link_a.sdi, link_a.output_latch_strobe_n}, 32'h9);
    expect_a(16'h0000);
    apb(1'b0, dac_link_pkg::SCK_DIV_OFFSET, 32'h0);
    check(rd, {24'h0, dac_link_pkg::SCK_DIV_RESET});
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("reset and register test done");
    send(16'h7abc);
    expect_a(16'h0000);
    apb(1'b1, dac_link_pkg::CTRL_OFFSET, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    expect_a(16'h7abc);
    apb(1'b0, dac_link_pkg::CTRL_OFFSET, 32'h0);
    check(rd, 32'h1);
    foreach (words[i]) begin
      send(words[i]);
      expect_a(words[i]);
    end
    send(16'h9555);
    expect_a(16'h5a5a);
    apb(1'b1, dac_link_pkg::CMD_OFFSET, 32'h1111);
    send(16'h1222);
    expect_a(16'h1111);
    apb(1'b0, dac_link_pkg::CMD_OFFSET, 32'h0);
    check(rd, 32'h1111);
    check(loads_a, 32'h6);
    $display("latch and command test done");
    apb(1'b1, dac_link_pkg::SCK_DIV_OFFSET, 32'h2);
    apb(1'b1, dac_link_pkg::SCK_DIV_OFFSET, 32'h0);
    apb(1'b0, dac_link_pkg::SCK_DIV_OFFSET, 32'h0);
    check(rd, 32'h2);
    send(16'h3c3c);
    expect_a(16'h3c3c);
    supply_low <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    supply_low <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    expect_a(16'h0000);
    send(16'h1abc);
    expect_a(16'h1abc);
    $display("divider and supply test done");
    frame(16'h3abc, 16, 1'b0);
    expect_b(16'h3abc);
    frame(16'h1f00, 10, 1'b0);
    expect_b(16'h3abc);
    frame(16'h1456, 20, 1'b0);
    expect_b(16'h1456);
    frame(16'h0fff, 16, 1'b1);
    expect_b(16'h1456);
    check(loads_b, 32'h2);
    $display("faulty frame test done");
    complete_run();
  end
endmodule
